/* rtl/cst_core_state.sv */
// Purpose: Architectural core state: register sets, byte order, link flag, PC
// Assumes: Instruction and mode inputs come from logic on sys_clk
// Notes:   Only the byte order strap is asynchronous and is synchronised
//
// Behaviour
// [RULE1] General register zero always reads zero; registers are 64 bits wide.
// [RULE2] Register references select within the set named by current shadow set.
// [RULE3] Memory byte order is captured at reset: 0 little, 1 big.
// [RULE4] Load/store byte order is memory byte order xor user order swap.
// [RULE5] User order swap only when swap bit set and in user mode.
// [RULE6] Linked load sets the link flag; conditional store tests it.
// [RULE7] Link flag clears on lost atomicity and on exception return.
// [RULE8] Unpredictable operations never touch state the mode cannot reach.
// [RULE9] Unpredictable operations give a defined result and never hang.
// [RULE10] Any reset returns the block to an operational state.
// [RULE11] Undefined-capable operations run only when kernel, debug or cu0 usable.
// [RULE12] Unstable samples return a value that was true earlier.
// [RULE13] Unstable values never come from inaccessible state.
// [RULE14] Bit fields number from bit 0; reversed selection yields empty field.
// [RULE15] Floating point condition flag 0 follows the coprocessor condition.
// [RULE16] Integer arithmetic and compares are two's complement.
// [RULE17] PC advances by 4, or 2 for compact instructions, unless redirected.
// [RULE18] Writes to general register zero are discarded.
`timescale 1ns/1ps
module cst_core_state
  import cst_pkg::*;
(
  // Clock and reset
  input  wire logic                     sys_clk,
  input  wire logic                     srst,
  input  wire logic                     clk_en,
  // Strap and mode
  input  wire logic                     byte_order_pin,
  input  wire cst_mode_t                priv_mode,
  input  wire logic                     debug_mode,
  input  wire logic                     cu0_usable,
  input  wire logic                     store_conflict,
  input  wire logic                     coprocessor_condition_signal,
  // Instruction in, result out
  input  wire cst_instr_t               instr,
  output cst_result_t                   result,
  output logic [GEN_REG_WIDTH-1:0]      pc,
  output logic                          running,
  // State outputs
  output logic                          memory_byte_order,
  output logic                          load_store_byte_order,
  output logic                          user_order_swap,
  output logic                          link_reservation_flag,
  output logic                          fp_condition_flag,
  output logic                          undefined_permitted,
  // Register port
  input  wire logic [ADDR_W-1:0]        reg_addr,
  input  wire logic [DATA_W-1:0]        reg_wdata,
  input  wire logic                     reg_wr,
  input  wire logic                     reg_rd,
  output logic [DATA_W-1:0]             reg_rdata
);

  cst_state_t                state;
  cst_state_t                next_state;
  logic                      strap_meta;
  logic                      strap_sync;
  logic                      mem_order;
  logic                      user_order_swap_bit;
  logic [SET_W-1:0]          current_shadow_set;
  logic [GEN_REG_WIDTH-1:0]  shadow_register_file [NUM_SETS*NUM_REGS];

  // Decode
  wire exec      = clk_en && state == ST_RUN && instr.valid;
  wire is_user   = priv_mode == MODE_USER && !debug_mode;
  wire undef_ok  = priv_mode == MODE_KERNEL || debug_mode || cu0_usable; // RULE11
  wire next_swap = user_order_swap_bit && is_user; // RULE5
  wire [SET_W+IDX_W-1:0] rs_ptr = {current_shadow_set, instr.rs}; // RULE2
  wire [SET_W+IDX_W-1:0] rt_ptr = {current_shadow_set, instr.rt}; // RULE2
  wire [SET_W+IDX_W-1:0] rd_ptr = {current_shadow_set, instr.rd}; // RULE2

  // Register zero is forced on read as well as never written
  wire [GEN_REG_WIDTH-1:0] op_a = (instr.rs == REG_ZERO) ? '0 : shadow_register_file[rs_ptr]; // RULE1
  wire [GEN_REG_WIDTH-1:0] op_b = (instr.rt == REG_ZERO) ? '0 : shadow_register_file[rt_ptr]; // RULE1
  wire signed [GEN_REG_WIDTH-1:0] sa = op_a; // RULE16
  wire signed [GEN_REG_WIDTH-1:0] sb = op_b; // RULE16
  wire div_zero = op_b == '0;

  // Field select: hi in op_b[13:8], lo in op_b[5:0]
  wire [5:0] f_hi = op_b[13:8];
  wire [5:0] f_lo = op_b[5:0];
  wire [6:0] f_len = 7'(f_hi) - 7'(f_lo) + 7'h01;
  wire [GEN_REG_WIDTH-1:0] f_mask = (f_len[6]) ? '1 : ~({GEN_REG_WIDTH{1'b1}} << f_len);
  wire [GEN_REG_WIDTH-1:0] f_val = (f_hi < f_lo) ? '0 : ((op_a >> f_lo) & f_mask); // RULE14

  wire [GEN_REG_WIDTH-1:0] p_mul = GEN_REG_WIDTH'(sa * sb);
  // Division by zero is unpredictable; a fixed zero keeps it from any other state
  wire [GEN_REG_WIDTH-1:0] p_div = div_zero ? '0 : GEN_REG_WIDTH'(sa / sb); // RULE9 RULE13
  wire [GEN_REG_WIDTH-1:0] p_mod = div_zero ? '0 : GEN_REG_WIDTH'(sa % sb); // RULE9 RULE13

  logic [GEN_REG_WIDTH-1:0] alu;
  always_comb begin
    case (instr.op)
      OP_ADD:  alu = op_a + op_b; // RULE16
      OP_SUB:  alu = op_a - op_b; // RULE16
      OP_MUL:  alu = p_mul; // RULE16
      OP_DIV:  alu = p_div; // RULE16
      OP_MOD:  alu = p_mod; // RULE16
      OP_SLT:  alu = {63'h0, sa < sb}; // RULE16
      OP_SGT:  alu = {63'h0, sa > sb}; // RULE16
      OP_SLE:  alu = {63'h0, sa <= sb}; // RULE16
      OP_SGE:  alu = {63'h0, sa >= sb}; // RULE16
      OP_EXT:  alu = f_val; // RULE14
      OP_SC:   alu = {63'h0, link_reservation_flag}; // RULE6
      default: alu = '0; // RULE8
    endcase
  end

  // A refused privileged op writes nothing, so user code cannot reach hidden state
  wire priv_fault = instr.op == OP_PRIV && !undef_ok; // RULE8 RULE11
  wire do_wb = exec && instr.wb && !priv_fault && instr.rd != REG_ZERO; // RULE18

  wire link_set = exec && instr.op == OP_LL; // RULE6
  wire link_clr = store_conflict || (exec && (instr.op == OP_ERET || instr.op == OP_SC)); // RULE7
  wire next_link = link_set || (link_reservation_flag && !link_clr);

  wire [GEN_REG_WIDTH-1:0] pc_step = instr.compact ? PC_STEP_SHORT : PC_STEP_WIDE; // RULE17
  wire [GEN_REG_WIDTH-1:0] next_pc = instr.redirect ? instr.target : pc + pc_step; // RULE17
  // Capture cycle passes the strap straight out so the order outputs are valid when running rises
  wire order_now = (state == ST_STRAP) ? strap_sync : mem_order; // RULE3

  // Sequencer: reset always lands in ST_RESET and walks back to ST_RUN
  always_comb begin
    case (state)
      ST_RESET: next_state = ST_STRAP;
      ST_STRAP: next_state = ST_RUN;
      ST_RUN:   next_state = ST_RUN;
      default:  next_state = ST_RESET; // RULE10
    endcase
  end

  // Register port decode
  wire wr_ctrl = reg_wr && reg_addr == ADDR_CTRL;
  logic [DATA_W-1:0] rd_mux;
  always_comb begin
    if (reg_addr == ADDR_CTRL) begin
      rd_mux = {29'h0, current_shadow_set, user_order_swap_bit};
    end else if (reg_addr == ADDR_STATUS) begin
      // Snapshot of flops: each bit was true at the previous edge
      rd_mux = {25'h0, running, undefined_permitted, fp_condition_flag,
                link_reservation_flag, user_order_swap, load_store_byte_order,
                memory_byte_order}; // RULE12
    end else if (reg_addr == ADDR_PC_LO) begin
      rd_mux = pc[31:0];
    end else if (reg_addr == ADDR_PC_HI) begin
      rd_mux = pc[63:32];
    end else begin
      rd_mux = '0;
    end
  end

  // Strap synchroniser; the pin is only read through strap_sync
  // Kept out of reset so the strap has crossed both flops by the capture cycle
  always_ff @(posedge sys_clk) begin
    if (clk_en) begin
      strap_meta <= byte_order_pin;
      strap_sync <= strap_meta;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      state <= ST_RESET; // RULE10
      mem_order <= 1'b0;
    end else if (clk_en) begin
      state <= next_state;
      if (state == ST_STRAP) mem_order <= strap_sync; // RULE3
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      {current_shadow_set, user_order_swap_bit} <= CTRL_RESET;
      reg_rdata <= '0;
    end else if (clk_en) begin
      if (wr_ctrl) begin
        user_order_swap_bit <= reg_wdata[CTRL_SWAP_BIT];
        current_shadow_set <= reg_wdata[CTRL_SET_LSB +: SET_W];
      end
      reg_rdata <= reg_rd ? rd_mux : '0;
    end
  end

  // Register sets are not reset; software must initialise them
  always_ff @(posedge sys_clk) begin
    if (clk_en && do_wb) shadow_register_file[rd_ptr] <= alu; // RULE18
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      pc <= PC_RESET;
      result <= '0;
      link_reservation_flag <= 1'b0;
    end else if (clk_en) begin
      if (exec && !priv_fault) pc <= next_pc; // RULE17
      result.valid <= exec;
      result.data <= priv_fault ? '0 : alu;
      result.sc_ok <= exec && instr.op == OP_SC && link_reservation_flag; // RULE6
      result.priv_fault <= exec && priv_fault; // RULE11
      link_reservation_flag <= next_link; // RULE6 RULE7
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      running <= 1'b0;
      memory_byte_order <= 1'b0;
      load_store_byte_order <= 1'b0;
      user_order_swap <= 1'b0;
      fp_condition_flag <= 1'b0;
      undefined_permitted <= 1'b0;
    end else if (clk_en) begin
      running <= next_state == ST_RUN;
      memory_byte_order <= order_now; // RULE3
      load_store_byte_order <= order_now ^ next_swap; // RULE4
      user_order_swap <= next_swap; // RULE5
      fp_condition_flag <= coprocessor_condition_signal; // RULE15
      undefined_permitted <= undef_ok; // RULE11
    end
  end

  // Checks
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (srst);

  a_gpr0_reads: assert property (exec && instr.rs == REG_ZERO && instr.op == OP_ADD && instr.rt == REG_ZERO
    |=> result.data == '0) // RULE1
    else $error("register zero did not read zero");
  a_gpr0_kept: assert property (clk_en && do_wb // RULE18
    |-> rd_ptr[IDX_W-1:0] != REG_ZERO)
    else $error("register zero was written");
  a_ls_order: assert property (clk_en |=>
    load_store_byte_order == (memory_byte_order ^ user_order_swap)) // RULE4
    else $error("load store byte order mismatch");
  a_swap_user: assert property (clk_en |=> user_order_swap ==
    ($past(user_order_swap_bit) && $past(priv_mode) == MODE_USER && !$past(debug_mode))) // RULE5
    else $error("order swap outside user mode");
  a_link_set: assert property (link_set |=> link_reservation_flag) // RULE6
    else $error("linked load did not set flag");
  a_link_clear: assert property (clk_en && exec && instr.op == OP_ERET && !link_set
    |=> !link_reservation_flag) // RULE7
    else $error("exception return left flag set");
  a_sc_test: assert property (exec && instr.op == OP_SC
    |=> result.sc_ok == $past(link_reservation_flag)) // RULE6
    else $error("conditional store ignored flag");
  a_priv_refused: assert property (exec && instr.op == OP_PRIV && !undef_ok
    |=> result.priv_fault && pc == $past(pc)) // RULE11
    else $error("privileged op ran unprivileged");
  a_pc_step: assert property (exec && !instr.redirect && instr.op != OP_PRIV
    |=> pc == $past(pc) + (($past(instr.compact)) ? PC_STEP_SHORT : PC_STEP_WIDE)) // RULE17
    else $error("pc did not step");
  a_fp_flag: assert property (clk_en |=> fp_condition_flag == $past(coprocessor_condition_signal)) // RULE15
    else $error("fp condition flag mismatch");
  a_div_zero: assert property (exec && instr.op == OP_DIV && div_zero |=> result.data == '0) // RULE9
    else $error("divide by zero result not zero");
  a_run_after_reset: assert property ($fell(srst) ##0 clk_en [*3] |-> running) // RULE10
    else $error("not running after reset");

  // Order, mode and sequencing
  a_order_fixed: assert property (running && $past(running) // RULE3
    |-> $stable(memory_byte_order))
    else $error("memory byte order changed while running");
  a_undef_flag: assert property (clk_en && !srst |=> undefined_permitted == // RULE11
    ($past(priv_mode) == MODE_KERNEL || $past(debug_mode) || $past(cu0_usable)))
    else $error("undefined permission flag wrong");
  a_stays_running: assert property (running && clk_en && !srst // RULE9
    |=> running)
    else $error("block left run state");
  a_idle_quiet: assert property (clk_en && !exec && !srst // RULE9
    |=> !result.valid)
    else $error("result shown without instruction");
  a_set_select: assert property (clk_en && wr_ctrl && !srst // RULE2
    |=> current_shadow_set == $past(reg_wdata[CTRL_SET_LSB +: SET_W]))
    else $error("shadow set not taken from write");

  // Data path and link flag
  a_link_conflict: assert property (clk_en && store_conflict && !link_set // RULE7
    |=> !link_reservation_flag)
    else $error("store conflict left flag set");
  a_ext_empty: assert property (exec && instr.op == OP_EXT && f_hi < f_lo // RULE14
    |=> result.data == '0)
    else $error("reversed field select not empty");
  a_fault_data: assert property (exec && priv_fault // RULE8
    |=> result.valid && result.data == '0)
    else $error("refused op returned data");
  a_pc_redirect: assert property (exec && instr.redirect && !priv_fault // RULE17
    |=> pc == $past(instr.target))
    else $error("pc did not follow redirect");

  c_ll_sc: cover property (link_set ##1 exec && instr.op == OP_SC ##1 result.sc_ok);
  c_swap: cover property (user_order_swap);
  c_fault: cover property (result.priv_fault);
  c_eret: cover property (exec && instr.op == OP_ERET && link_reservation_flag);
  // Recovery to run after any reset, including the first
  c_reset_run: cover property ($fell(srst) ##2 running);

endmodule : cst_core_state

/* rtl/cst_pkg.sv */
// Purpose: Shared constants and types for the core state block
// Assumes: One clock, synchronous active-high reset
// Notes:   Register offsets are byte addresses on a 32-bit port
package cst_pkg;
  localparam int GEN_REG_WIDTH  = 64;
  localparam int NUM_REGS       = 32;
  localparam int NUM_SETS       = 4;
  localparam int SET_W          = 2;
  localparam int IDX_W          = 5;
  localparam int ADDR_W         = 8;
  localparam int DATA_W         = 32;

  localparam logic [IDX_W-1:0]         REG_ZERO      = 5'h00;
  localparam logic [GEN_REG_WIDTH-1:0] PC_RESET      = 64'h0;
  localparam logic [GEN_REG_WIDTH-1:0] PC_STEP_WIDE  = 64'h4;
  localparam logic [GEN_REG_WIDTH-1:0] PC_STEP_SHORT = 64'h2;

  localparam logic [ADDR_W-1:0] ADDR_CTRL   = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h04;
  localparam logic [ADDR_W-1:0] ADDR_PC_LO  = 8'h08;
  localparam logic [ADDR_W-1:0] ADDR_PC_HI  = 8'h0C;

  localparam int CTRL_SWAP_BIT = 0;
  localparam int CTRL_SET_LSB  = 1;
  localparam logic [SET_W:0] CTRL_RESET = 3'h0;

  localparam int ST_MEM_ORDER = 0;
  localparam int ST_LS_ORDER  = 1;
  localparam int ST_SWAP      = 2;
  localparam int ST_LINK      = 3;
  localparam int ST_FP_FLAG   = 4;
  localparam int ST_UNDEF_OK  = 5;
  localparam int ST_RUNNING   = 6;

  typedef enum logic [1:0] {
    MODE_KERNEL = 2'h0,
    MODE_SUPER  = 2'h1,
    MODE_USER   = 2'h2
  } cst_mode_t;

  typedef enum logic [3:0] {
    OP_NOP = 4'h0, OP_ADD = 4'h1, OP_SUB = 4'h2, OP_MUL = 4'h3,
    OP_DIV = 4'h4, OP_MOD = 4'h5, OP_SLT = 4'h6, OP_SGT = 4'h7,
    OP_SLE = 4'h8, OP_SGE = 4'h9, OP_EXT = 4'hA, OP_LL  = 4'hB,
    OP_SC  = 4'hC, OP_ERET = 4'hD, OP_PRIV = 4'hE
  } cst_op_t;

  // Gray codes along reset -> strap capture -> run
  typedef enum logic [1:0] {
    ST_RESET = 2'b00,
    ST_STRAP = 2'b01,
    ST_RUN   = 2'b11
  } cst_state_t;

  typedef struct packed {
    logic                     valid;
    cst_op_t                  op;
    logic [IDX_W-1:0]         rs;
    logic [IDX_W-1:0]         rt;
    logic [IDX_W-1:0]         rd;
    logic                     wb;
    logic                     compact;
    logic                     redirect;
    logic [GEN_REG_WIDTH-1:0] target;
  } cst_instr_t;

  typedef struct packed {
    logic                     valid;
    logic [GEN_REG_WIDTH-1:0] data;
    logic                     sc_ok;
    logic                     priv_fault;
  } cst_result_t;
endpackage : cst_pkg

/* dv/cst_core_state_tb.sv */
// Purpose: Self-checking bench for the core state block
// Assumes: Strap pin tied big endian; register contents are built from r0 only
// Notes:   Register file is not reset, so every operand is made before use
`timescale 1ns/1ps
module testbench
  import cst_pkg::*;
;
  logic                     sys_clk = 1'b0;
  logic                     srst;
  logic                     clk_en;
  logic                     byte_order_pin;
  cst_mode_t                priv_mode;
  logic                     debug_mode;
  logic                     cu0_usable;
  logic                     store_conflict;
  logic                     cond;
  cst_instr_t               instr;
  cst_result_t              result;
  logic [GEN_REG_WIDTH-1:0] pc;
  logic [GEN_REG_WIDTH-1:0] pc_exp;
  logic                     running;
  logic                     mem_o;
  logic                     ls_o;
  logic                     swap_o;
  logic                     link_o;
  logic                     fp_o;
  logic                     undef_o;
  logic [ADDR_W-1:0]        reg_addr;
  logic [DATA_W-1:0]        reg_wdata;
  logic [DATA_W-1:0]        reg_rdata;
  logic [DATA_W-1:0]        rd_val;
  logic                     reg_wr;
  logic                     reg_rd;
  int                       err_count;
  int                       n_checks;
  int                       cycles;

  always #4 sys_clk = ~sys_clk;

  cst_core_state u_cst_core_state (
    .sys_clk(sys_clk), .srst(srst), .clk_en(clk_en), .byte_order_pin(byte_order_pin),
    .priv_mode(priv_mode), .debug_mode(debug_mode), .cu0_usable(cu0_usable),
    .store_conflict(store_conflict), .coprocessor_condition_signal(cond), .instr(instr),
    .result(result), .pc(pc), .running(running), .memory_byte_order(mem_o),
    .load_store_byte_order(ls_o), .user_order_swap(swap_o), .link_reservation_flag(link_o),
    .fp_condition_flag(fp_o), .undefined_permitted(undef_o), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata)
  );

  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic results;
    $display("checks=%0d mismatches=%0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : results

  // Hang guard: the whole sequence needs well under a thousand cycles
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles > 3000) begin
      err_count++;
      results();
    end
  end

  task automatic reg_write(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge sys_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask : reg_write

  task automatic reg_read(input logic [ADDR_W-1:0] a);
    @(posedge sys_clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1;
    rd_val = reg_rdata;
  endtask : reg_read

  task automatic ex(input cst_op_t o, input logic [4:0] s, input logic [4:0] t, input logic [4:0] d,
                    input logic [2:0] f, input logic [63:0] tgt = 64'h0);
    logic ok;
    @(posedge sys_clk);
    // Mode is read at the edge so a mode change queued just before the call counts
    ok = (priv_mode == MODE_KERNEL) || debug_mode || cu0_usable;
    instr <= '{1'b1, o, s, t, d, f[2], f[1], f[0], tgt};
    @(posedge sys_clk);
    instr.valid <= 1'b0;
    #1;
    if (!(o == OP_PRIV && !ok)) begin
      pc_exp = f[0] ? tgt : pc_exp + (f[1] ? PC_STEP_SHORT : PC_STEP_WIDE);
    end
    chk(result.valid, 1'b1);
    chk(result.priv_fault, (o == OP_PRIV) && !ok);
    chk(pc, pc_exp);
  endtask : ex

  task automatic start_up;
    int n;
    n = 0;
    // Look after the reset edge has landed, or a stale running flag ends the wait
    #1;
    while (running !== 1'b1 && n < 20) begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    chk(running, 1'b1);
    pc_exp = PC_RESET;
  endtask : start_up

  task automatic settle;
    repeat (2) @(posedge sys_clk);
    #1;
  endtask : settle

  initial begin
    srst = 1'b1; clk_en = 1'b1; byte_order_pin = 1'b1; priv_mode = MODE_KERNEL;
    debug_mode = 1'b0; cu0_usable = 1'b0; store_conflict = 1'b0; cond = 1'b0;
    instr = '0; reg_addr = '0; reg_wdata = '0; reg_wr = 1'b0; reg_rd = 1'b0;
    err_count = 0; n_checks = 0; cycles = 0;
    repeat (3) @(posedge sys_clk);
    srst <= 1'b0;
    start_up();
    chk(mem_o, 1'b1);
    reg_read(ADDR_STATUS);
    chk(rd_val, 32'h63);
    reg_read(8'h40);
    chk(rd_val, 32'h0);
    $display("reset test done");
    ex(OP_SLE, 5'h00, 5'h00, 5'h01, 3'b100); chk(result.data, 64'h1);
    ex(OP_SUB, 5'h00, 5'h01, 5'h02, 3'b100); chk(result.data, '1);
    ex(OP_SLT, 5'h02, 5'h01, 5'h03, 3'b100); chk(result.data, 64'h1);
    ex(OP_SGT, 5'h02, 5'h01, 5'h03, 3'b100); chk(result.data, 64'h0);
    ex(OP_MUL, 5'h02, 5'h02, 5'h03, 3'b100); chk(result.data, 64'h1);
    ex(OP_DIV, 5'h02, 5'h01, 5'h03, 3'b100); chk(result.data, '1);
    ex(OP_MOD, 5'h02, 5'h01, 5'h03, 3'b100); chk(result.data, 64'h0);
    ex(OP_DIV, 5'h01, 5'h00, 5'h03, 3'b100); chk(result.data, 64'h0);
    ex(OP_ADD, 5'h01, 5'h01, 5'h00, 3'b100);
    ex(OP_ADD, 5'h00, 5'h00, 5'h04, 3'b100); chk(result.data, 64'h0);
    ex(OP_EXT, 5'h02, 5'h01, 5'h04, 3'b000); chk(result.data, 64'h0);
    ex(OP_EXT, 5'h02, 5'h00, 5'h04, 3'b000); chk(result.data, 64'h1);
    $display("arithmetic test done");
    // Set 1 gets its own r2 = 2, set 0 keeps r2 = -1
    reg_write(ADDR_CTRL, 32'h2);
    reg_read(ADDR_CTRL);
    chk(rd_val, 32'h2);
    ex(OP_SLE, 5'h00, 5'h00, 5'h01, 3'b100);
    ex(OP_ADD, 5'h01, 5'h01, 5'h02, 3'b100); chk(result.data, 64'h2);
    reg_write(ADDR_CTRL, 32'h0);
    ex(OP_ADD, 5'h02, 5'h00, 5'h05, 3'b100); chk(result.data, '1);
    ex(OP_NOP, 5'h00, 5'h00, 5'h00, 3'b010);
    ex(OP_NOP, 5'h00, 5'h00, 5'h00, 3'b001, 64'h100);
    reg_read(ADDR_PC_LO);
    chk(rd_val, pc_exp[31:0]);
    reg_read(ADDR_PC_HI);
    chk(rd_val, pc_exp[63:32]);
    $display("register set and pc test done");
    ex(OP_LL, 5'h00, 5'h00, 5'h00, 3'b000); chk(link_o, 1'b1);
    ex(OP_SC, 5'h00, 5'h00, 5'h00, 3'b000); chk(result.sc_ok, 1'b1);
    chk(link_o, 1'b0);
    ex(OP_SC, 5'h00, 5'h00, 5'h00, 3'b000); chk(result.sc_ok, 1'b0);
    ex(OP_LL, 5'h00, 5'h00, 5'h00, 3'b000);
    ex(OP_ERET, 5'h00, 5'h00, 5'h00, 3'b000); chk(link_o, 1'b0);
    ex(OP_LL, 5'h00, 5'h00, 5'h00, 3'b000);
    @(posedge sys_clk);
    store_conflict <= 1'b1;
    @(posedge sys_clk);
    store_conflict <= 1'b0;
    #1;
    chk(link_o, 1'b0);
    // With the clock enable low the flag must hold its old value
    @(posedge sys_clk);
    clk_en <= 1'b0;
    cond   <= 1'b1;
    settle();
    chk(fp_o, 1'b0);
    clk_en <= 1'b1;
    settle();
    chk(fp_o, 1'b1);
    $display("link and condition test done");
    reg_write(ADDR_CTRL, 32'h1);
    priv_mode <= MODE_USER;
    settle();
    chk(swap_o, 1'b1);
    chk(ls_o, 1'b0);
    chk(undef_o, 1'b0);
    ex(OP_PRIV, 5'h02, 5'h02, 5'h05, 3'b100); chk(result.data, 64'h0);
    ex(OP_ADD, 5'h05, 5'h00, 5'h06, 3'b000); chk(result.data, '1);
    debug_mode <= 1'b1;
    settle();
    chk(swap_o, 1'b0);
    chk(undef_o, 1'b1);
    ex(OP_PRIV, 5'h00, 5'h00, 5'h00, 3'b000);
    debug_mode <= 1'b0;
    cu0_usable <= 1'b1;
    ex(OP_PRIV, 5'h00, 5'h00, 5'h00, 3'b000);
    cu0_usable <= 1'b0;
    priv_mode  <= MODE_SUPER;
    cond       <= 1'b0;
    settle();
    chk(swap_o, 1'b0);
    chk(ls_o, 1'b1);
    $display("mode test done");
    // Second reset in mid-run must bring the block back to work
    @(posedge sys_clk);
    srst <= 1'b1;
    @(posedge sys_clk);
    srst <= 1'b0;
    start_up();
    chk(pc, PC_RESET);
    reg_read(ADDR_STATUS);
    chk(rd_val, 32'h43);
    ex(OP_SLE, 5'h00, 5'h00, 5'h07, 3'b100); chk(result.data, 64'h1);
    $display("reset recovery test done");
    results();
  end
endmodule : testbench
